// File: rtl/psmm_core_map.sv
// psmm_core_map: status word, internal data memory decode and unified code/xdata map.
// assumes sfr_rdata_i, ext_mapped_ctrl_regs_rdata_i and rom_rdata_i answer in the same cycle as their address.
// Function
// (R1) carry set on carry/borrow, else cleared
// (R2) aux carry tracks nibble carry or borrow
// (R3) two user flags touched only by software
// (R4) bank select picks register bank base
// (R5) overflow on signed add or subtract wrap
// (R6) overflow when product exceeds 255
// (R7) overflow on divide by zero
// (R8) those ops clear overflow otherwise
// (R9) parity bit follows accumulator odd parity
// (R10) status word at 0xD0, bit-addressable, resets zero
// (R11) low 128 bytes direct and indirect
// (R12) bytes 0x20-0x2F also bit addressable
// (R13) direct above 0x7F goes to registers
// (R14) indirect above 0x7F reaches upper RAM
// (R15) one RAM serves code and data reads
// (R16) ROM executes only; data reads undefined
// (R17) nonvolatile arrays absent from address map
// (R18) control register window decoded in xdata
// (R19) status word write leaves parity alone
`timescale 1ns/100ps
module psmm_core_map #(
  parameter int CRAM_BYTES = psmm_pkg::CRAM_BYTES
) (
  input logic core_clk_i,
  input logic rst_i,
  input logic [7:0] acc_i,
  input psmm_pkg::psmm_arith_t arith_op_i,
  input logic [7:0] arith_a_i,
  input logic [7:0] arith_b_i,
  output logic [7:0] psw_o,
  input logic iram_req_i,
  input logic iram_we_i,
  input psmm_pkg::psmm_imode_t iram_mode_i,
  input logic [7:0] iram_addr_i,
  input logic [2:0] reg_idx_i,
  input logic [7:0] iram_wdata_i,
  output logic [7:0] iram_rdata_o,
  output logic iram_ack_o,
  output logic sfr_req_o,
  output logic sfr_we_o,
  output logic [7:0] sfr_addr_o,
  output logic [7:0] sfr_wdata_o,
  input logic [7:0] sfr_rdata_i,
  input logic code_req_i,
  input psmm_pkg::psmm_cread_t code_kind_i,
  input logic [15:0] code_addr_i,
  output logic [7:0] code_rdata_o,
  output logic code_ack_o,
  output logic [15:0] rom_addr_o,
  input logic [7:0] rom_rdata_i,
  input logic xdat_req_i,
  input logic xdat_we_i,
  input logic [15:0] xdat_addr_i,
  input logic [7:0] xdat_wdata_i,
  output logic [7:0] xdat_rdata_o,
  output logic xdat_ack_o,
  output logic ext_mapped_ctrl_regs_req_o,
  output logic ext_mapped_ctrl_regs_we_o,
  output logic [7:0] ext_mapped_ctrl_regs_addr_o,
  output logic [7:0] ext_mapped_ctrl_regs_wdata_o,
  input logic [7:0] ext_mapped_ctrl_regs_rdata_i
);
  localparam int CRAM_AW = $clog2(CRAM_BYTES);

  // the unified RAM must sit below the control register window
  if (CRAM_BYTES < 2 || CRAM_BYTES > psmm_pkg::EXT_MAPPED_CTRL_REGS_BASE) begin : g_bad_cram
    $error("psmm_core_map: CRAM_BYTES out of range");
  end

  logic [7:0] iram_mem [psmm_pkg::IRAM_BYTES];
  logic [7:0] cram_mem [CRAM_BYTES];
  logic [7:1] psw_reg, psw_next;
  logic [7:0] irdat_reg, irdat_next;
  logic [7:0] crdat_reg, crdat_next;
  logic [7:0] xrdat_reg, xrdat_next;
  logic iack_reg, cack_reg, xack_reg;
  logic [7:0] byte_addr, old_byte, wr_byte, psw_full;
  logic to_sfr, psw_hit, psw_sw_we, ram_we, bit_val;
  logic code_in_cram, code_in_rom, xdat_in_cram, xdat_in_ext_mapped_ctrl_regs, xdat_in_rom, cram_we;
  logic [CRAM_AW-1:0] cram_widx;

  psmm_arith_if ar_if ();
  psmm_flag_calc u_calc (
    .ar(ar_if.calc)
  );
  assign ar_if.op = arith_op_i;
  assign ar_if.a = arith_a_i;
  assign ar_if.b = arith_b_i;
  assign ar_if.cin = psw_reg[psmm_pkg::CY_BIT];

  // parity is derived, never stored, so it tracks the accumulator each cycle
  assign psw_full = {psw_reg, ^acc_i}; // [R9] [R19]
  assign psw_o = psw_full;

  // internal memory decode: register, bit and direct/indirect byte addresses
  always_comb begin
    byte_addr = iram_addr_i;
    unique case (iram_mode_i)
      psmm_pkg::IMODE_REG: byte_addr = {3'b000, psw_reg[psmm_pkg::BANK_HI:psmm_pkg::BANK_LO], reg_idx_i}; // [R4]
      psmm_pkg::IMODE_BIT: begin
        // bit addresses below 0x80 land in 0x20-0x2F, above in byte-aligned registers
        byte_addr = iram_addr_i[7] ? {iram_addr_i[7:3], 3'b000}
                                   : (psmm_pkg::BIT_RAM_BASE | {4'h0, iram_addr_i[6:3]}); // [R12]
      end
      psmm_pkg::IMODE_DIRECT: byte_addr = iram_addr_i; // [R11]
      psmm_pkg::IMODE_INDIRECT: byte_addr = iram_addr_i; // [R11] [R14]
    endcase
    // only direct-style accesses above 0x7F see the register space
    to_sfr = (iram_mode_i == psmm_pkg::IMODE_DIRECT || iram_mode_i == psmm_pkg::IMODE_BIT)
             && byte_addr[7]; // [R13] [R14]
    psw_hit = to_sfr && (byte_addr == psmm_pkg::PSW_ADDR); // [R10]
    old_byte = psw_hit ? psw_full : (to_sfr ? sfr_rdata_i : iram_mem[byte_addr]);
    bit_val = old_byte[iram_addr_i[2:0]];
    wr_byte = iram_wdata_i;
    if (iram_mode_i == psmm_pkg::IMODE_BIT) begin
      // bit write is read-modify-write of the owning byte
      wr_byte = old_byte;
      wr_byte[iram_addr_i[2:0]] = iram_wdata_i[0];
    end
    ram_we = iram_req_i && iram_we_i && !to_sfr;
    psw_sw_we = iram_req_i && iram_we_i && psw_hit;
  end

  // register space requests other than the status word go out
  assign sfr_req_o = iram_req_i && to_sfr && !psw_hit; // [R13]
  assign sfr_we_o = iram_req_i && iram_we_i && to_sfr && !psw_hit;
  assign sfr_addr_o = byte_addr;
  assign sfr_wdata_o = wr_byte;

  // status word next value: software first, arithmetic results override
  always_comb begin
    psw_next = psw_reg;
    if (psw_sw_we) begin
      psw_next = wr_byte[7:1]; // bit 0 has no storage [R19] [R3]
    end
    if (arith_op_i != psmm_pkg::ARITH_NONE) begin
      psw_next[psmm_pkg::CY_BIT] = ar_if.cy; // [R1]
      psw_next[psmm_pkg::AC_BIT] = ar_if.ac; // [R2]
      psw_next[psmm_pkg::OV_BIT] = ar_if.ov; // [R5] [R6] [R7] [R8]
    end
    irdat_next = irdat_reg;
    if (iram_req_i && !iram_we_i) begin
      irdat_next = (iram_mode_i == psmm_pkg::IMODE_BIT) ? {7'h00, bit_val} : old_byte;
    end
  end

  // status word and internal read data registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      psw_reg <= psmm_pkg::PSW_RESET[7:1]; // [R10]
      irdat_reg <= 8'h00;
      iack_reg <= 1'b0;
    end else begin
      psw_reg <= psw_next;
      irdat_reg <= irdat_next;
      iack_reg <= iram_req_i;
    end
  end

  // one array holds low RAM and the indirect-only upper half
  always_ff @(posedge core_clk_i) begin
    if (ram_we) begin
      iram_mem[byte_addr] <= wr_byte; // [R11] [R14]
    end
  end
  assign iram_rdata_o = irdat_reg;
  assign iram_ack_o = iack_reg;
  // unified space decode; nothing maps the nonvolatile arrays [R17]
  assign code_in_cram = int'(code_addr_i) < CRAM_BYTES;
  assign code_in_rom = int'(code_addr_i) >= psmm_pkg::ROM_BASE
                       && int'(code_addr_i) < psmm_pkg::ROM_BASE + psmm_pkg::ROM_BYTES;
  assign xdat_in_cram = int'(xdat_addr_i) < CRAM_BYTES;
  assign xdat_in_ext_mapped_ctrl_regs = int'(xdat_addr_i) >= psmm_pkg::EXT_MAPPED_CTRL_REGS_BASE
                        && int'(xdat_addr_i) < psmm_pkg::EXT_MAPPED_CTRL_REGS_BASE + psmm_pkg::EXT_MAPPED_CTRL_REGS_BYTES; // [R18]
  assign xdat_in_rom = int'(xdat_addr_i) >= psmm_pkg::ROM_BASE
                       && int'(xdat_addr_i) < psmm_pkg::ROM_BASE + psmm_pkg::ROM_BYTES;
  assign rom_addr_o = code_addr_i - 16'(psmm_pkg::ROM_BASE);

  // control register window is forwarded, the data move alone reaches it
  assign ext_mapped_ctrl_regs_req_o = xdat_req_i && xdat_in_ext_mapped_ctrl_regs; // [R18]
  assign ext_mapped_ctrl_regs_we_o = xdat_req_i && xdat_we_i && xdat_in_ext_mapped_ctrl_regs;
  assign ext_mapped_ctrl_regs_addr_o = xdat_addr_i[7:0];
  assign ext_mapped_ctrl_regs_wdata_o = xdat_wdata_i;

  // read data for code and data ports; ROM is hidden from data reads
  always_comb begin
    crdat_next = crdat_reg;
    xrdat_next = xrdat_reg;
    cram_we = xdat_req_i && xdat_we_i && xdat_in_cram; // [R15]
    cram_widx = xdat_addr_i[CRAM_AW-1:0];
    if (code_req_i) begin
      if (code_in_cram) begin
        crdat_next = cram_mem[code_addr_i[CRAM_AW-1:0]]; // fetch and code_space_read_instr alike [R15]
      end else if (code_in_rom && code_kind_i == psmm_pkg::CREAD_FETCH) begin
        crdat_next = rom_rdata_i;
      end else begin
        crdat_next = psmm_pkg::UNDEF_BYTE; // [R16]
      end
    end
    if (xdat_req_i && !xdat_we_i) begin
      if (xdat_in_cram) begin
        xrdat_next = cram_mem[cram_widx]; // [R15]
      end else if (xdat_in_ext_mapped_ctrl_regs) begin
        xrdat_next = ext_mapped_ctrl_regs_rdata_i;
      end else begin
        xrdat_next = xdat_in_rom ? psmm_pkg::UNDEF_BYTE : 8'h00; // [R16]
      end
    end
  end

  // code and data read registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      crdat_reg <= 8'h00;
      xrdat_reg <= 8'h00;
      cack_reg <= 1'b0;
      xack_reg <= 1'b0;
    end else begin
      crdat_reg <= crdat_next;
      xrdat_reg <= xrdat_next;
      cack_reg <= code_req_i;
      xack_reg <= xdat_req_i;
    end
  end

  // unified RAM storage, written only by the data move port
  always_ff @(posedge core_clk_i) begin
    if (cram_we) begin
      cram_mem[cram_widx] <= xdat_wdata_i;
    end
  end
  assign code_rdata_o = crdat_reg;
  assign code_ack_o = cack_reg;
  assign xdat_rdata_o = xrdat_reg;
  assign xdat_ack_o = xack_reg;
  // checking helpers, computed independently of the datapath
  logic [8:0] chk_sum9;
  logic [4:0] chk_nib5;
  logic [15:0] chk_prod;
  logic [7:0] chk_reg_addr, chk_bit_byte;
  logic [2:0] chk_bit_pos;
  logic [6:0] chk_wr_hi;
  logic chk_par, chk_bit_val, chk_ovadd;
  assign chk_sum9 = {1'b0, arith_a_i} + {1'b0, arith_b_i};
  assign chk_nib5 = {1'b0, arith_a_i[3:0]} + {1'b0, arith_b_i[3:0]};
  assign chk_prod = {8'h00, arith_a_i} * {8'h00, arith_b_i};
  assign chk_ovadd = (arith_a_i[7] == arith_b_i[7]) && (chk_sum9[7] != arith_a_i[7]);
  assign chk_reg_addr = {3'b000, psw_o[4:3], reg_idx_i};
  assign chk_bit_byte = psmm_pkg::BIT_RAM_BASE | {4'h0, iram_addr_i[6:3]};
  assign chk_bit_pos = iram_addr_i[2:0];
  assign chk_bit_val = iram_wdata_i[0];
  assign chk_wr_hi = iram_wdata_i[7:1];
  assign chk_par = ^acc_i;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_cy_add;
    arith_op_i == psmm_pkg::ARITH_ADD |=> psw_o[7] == $past(chk_sum9[8]);
  endproperty
  a_cy_add: assert property (p_cy_add) else $error("carry wrong after add"); // [R1]
  property p_ac_add;
    arith_op_i == psmm_pkg::ARITH_ADD |=> psw_o[6] == $past(chk_nib5[4]);
  endproperty
  a_ac_add: assert property (p_ac_add) else $error("aux carry wrong after add"); // [R2]
  property p_user_flags;
    !psw_sw_we |=> $stable(psw_o[5]) && $stable(psw_o[1]);
  endproperty
  a_user_flags: assert property (p_user_flags) else $error("user flag changed by hardware"); // [R3]
  property p_reg_bank;
    iram_req_i && iram_we_i && iram_mode_i == psmm_pkg::IMODE_REG
      |=> iram_mem[$past(chk_reg_addr)] == $past(iram_wdata_i);
  endproperty
  a_reg_bank: assert property (p_reg_bank) else $error("register write missed its bank"); // [R4]
  property p_ov_add;
    arith_op_i == psmm_pkg::ARITH_ADD |=> psw_o[2] == $past(chk_ovadd);
  endproperty
  a_ov_add: assert property (p_ov_add) else $error("overflow wrong after add"); // [R5]
  property p_ov_mul;
    arith_op_i == psmm_pkg::ARITH_MUL |=> psw_o[2] == ($past(chk_prod) > 16'h00FF) && !psw_o[7];
  endproperty
  a_ov_mul: assert property (p_ov_mul) else $error("overflow wrong after multiply"); // [R6]
  property p_ov_div;
    arith_op_i == psmm_pkg::ARITH_DIV |=> psw_o[2] == ($past(arith_b_i) == 8'h00);
  endproperty
  a_ov_div: assert property (p_ov_div) else $error("overflow wrong after divide"); // [R7]
  property p_ov_clear;
    arith_op_i == psmm_pkg::ARITH_DIV && arith_b_i != 8'h00 |=> !psw_o[2] && !psw_o[6];
  endproperty
  a_ov_clear: assert property (p_ov_clear) else $error("overflow not cleared"); // [R8]
  property p_parity_read;
    iram_req_i && !iram_we_i && iram_mode_i == psmm_pkg::IMODE_DIRECT && iram_addr_i == psmm_pkg::PSW_ADDR
      |=> iram_rdata_o[0] == $past(chk_par);
  endproperty
  a_parity_read: assert property (p_parity_read) else $error("parity read wrong"); // [R9]
  property p_reset_zero;
    $fell(rst_i) |-> psw_o[7:1] == 7'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("status word not zero after reset"); // [R10]
  property p_bit_ram;
    iram_req_i && iram_we_i && iram_mode_i == psmm_pkg::IMODE_BIT && !iram_addr_i[7]
      |=> iram_mem[$past(chk_bit_byte)][$past(chk_bit_pos)] == $past(chk_bit_val);
  endproperty
  a_bit_ram: assert property (p_bit_ram) else $error("bit write missed"); // [R12]
  property p_direct_high;
    iram_req_i && iram_mode_i == psmm_pkg::IMODE_DIRECT && iram_addr_i[7]
      |-> !ram_we && (sfr_req_o || iram_addr_i == psmm_pkg::PSW_ADDR);
  endproperty
  a_direct_high: assert property (p_direct_high) else $error("direct high access hit RAM"); // [R13]
  property p_indirect_high;
    iram_req_i && iram_we_i && iram_mode_i == psmm_pkg::IMODE_INDIRECT && iram_addr_i[7]
      |-> !sfr_req_o ##1 iram_mem[$past(iram_addr_i)] == $past(iram_wdata_i);
  endproperty
  a_indirect_high: assert property (p_indirect_high) else $error("indirect high write lost"); // [R14]
  property p_unified;
    xdat_req_i && xdat_we_i && xdat_in_cram ##1 code_req_i && code_addr_i == $past(xdat_addr_i)
      |=> code_rdata_o == $past(xdat_wdata_i, 2);
  endproperty
  a_unified: assert property (p_unified) else $error("code read missed data write"); // [R15]
  property p_rom_hidden;
    code_req_i && code_in_rom && code_kind_i == psmm_pkg::CREAD_CODE_SPACE_READ_INSTR |=> code_rdata_o == psmm_pkg::UNDEF_BYTE;
  endproperty
  a_rom_hidden: assert property (p_rom_hidden) else $error("ROM contents leaked"); // [R16]
  property p_ext_mapped_ctrl_regs_win;
    xdat_req_i && xdat_in_ext_mapped_ctrl_regs |-> ext_mapped_ctrl_regs_req_o && !cram_we && ext_mapped_ctrl_regs_addr_o == xdat_addr_i[7:0];
  endproperty
  a_ext_mapped_ctrl_regs_win: assert property (p_ext_mapped_ctrl_regs_win) else $error("control window not decoded"); // [R18]
  property p_psw_write;
    psw_sw_we && arith_op_i == psmm_pkg::ARITH_NONE && iram_mode_i == psmm_pkg::IMODE_DIRECT
      |=> psw_o[7:1] == $past(chk_wr_hi);
  endproperty
  a_psw_write: assert property (p_psw_write) else $error("status word write wrong"); // [R19]
  c_add_carry: cover property (arith_op_i == psmm_pkg::ARITH_ADD ##1 psw_o[7]);
  c_div_zero: cover property (arith_op_i == psmm_pkg::ARITH_DIV ##1 psw_o[2]);
  c_upper_ram: cover property (iram_req_i && iram_mode_i == psmm_pkg::IMODE_INDIRECT && iram_addr_i[7]);
  c_rom_code_space_read_instr: cover property (code_req_i && code_in_rom && code_kind_i == psmm_pkg::CREAD_CODE_SPACE_READ_INSTR);

endmodule : psmm_core_map

// File: rtl/psmm_pkg.sv
// psmm_pkg: constants and types shared by the status word and memory map logic.
// assumes an 8-bit core that presents one operand access per request cycle.
package psmm_pkg;

  // status word location and bit positions
  localparam logic [7:0] PSW_ADDR = 8'hD0;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam int CY_BIT = 7;
  localparam int AC_BIT = 6;
  localparam int F0_BIT = 5;
  localparam int BANK_HI = 4;
  localparam int BANK_LO = 3;
  localparam int OV_BIT = 2;
  localparam int F1_BIT = 1;
  localparam int PAR_BIT = 0;

  // internal data memory
  localparam int IRAM_BYTES = 256;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;

  // unified code/xdata space, in bytes
  localparam int CRAM_BYTES = 4608;
  localparam int EXT_MAPPED_CTRL_REGS_BASE = 16384;
  localparam int EXT_MAPPED_CTRL_REGS_BYTES = 256;
  localparam int ROM_BASE = 32768;
  localparam int ROM_BYTES = 12288;
  localparam logic [7:0] UNDEF_BYTE = 8'hFF;

  typedef enum logic [2:0] {
    ARITH_NONE,
    ARITH_ADD,
    ARITH_ADDC,
    ARITH_SUBB,
    ARITH_MUL,
    ARITH_DIV
  } psmm_arith_t;

  typedef enum logic [1:0] {
    IMODE_DIRECT,
    IMODE_INDIRECT,
    IMODE_BIT,
    IMODE_REG
  } psmm_imode_t;

  typedef enum logic {
    CREAD_FETCH,
    CREAD_CODE_SPACE_READ_INSTR
  } psmm_cread_t;

endpackage : psmm_pkg

// File: rtl/psmm_arith_if.sv
// psmm_arith_if: operands and flag results between the core map and the flag calculator.
// assumes purely combinational use inside one clock domain.
`timescale 1ns/100ps
interface psmm_arith_if;
  psmm_pkg::psmm_arith_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic cy;
  logic ac;
  logic ov;
  modport calc (input op, input a, input b, input cin, output cy, output ac, output ov);
  modport user (output op, output a, output b, output cin, input cy, input ac, input ov);
endinterface : psmm_arith_if

// File: rtl/psmm_flag_calc.sv
// psmm_flag_calc: carry, auxiliary carry and overflow for one arithmetic operation.
// assumes operands are stable during the cycle the operation is offered.
`timescale 1ns/100ps
module psmm_flag_calc (
  psmm_arith_if.calc ar
);
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [15:0] prod;
  logic ci;

  // flags default to clear, so any op that does not set one clears it
  always_comb begin
    sum9 = 9'h000;
    nib5 = 5'h00;
    prod = 16'h0000;
    ci = 1'b0;
    ar.cy = 1'b0;
    ar.ac = 1'b0;
    ar.ov = 1'b0;
    unique case (ar.op)
      psmm_pkg::ARITH_ADD, psmm_pkg::ARITH_ADDC: begin
        ci = (ar.op == psmm_pkg::ARITH_ADDC) ? ar.cin : 1'b0;
        sum9 = {1'b0, ar.a} + {1'b0, ar.b} + {8'h00, ci};
        nib5 = {1'b0, ar.a[3:0]} + {1'b0, ar.b[3:0]} + {4'h0, ci};
        ar.cy = sum9[8]; // [R1]
        ar.ac = nib5[4]; // [R2]
        ar.ov = (ar.a[7] == ar.b[7]) && (sum9[7] != ar.a[7]); // [R5]
      end
      psmm_pkg::ARITH_SUBB: begin
        sum9 = {1'b0, ar.a} - {1'b0, ar.b} - {8'h00, ar.cin};
        nib5 = {1'b0, ar.a[3:0]} - {1'b0, ar.b[3:0]} - {4'h0, ar.cin};
        ar.cy = sum9[8]; // borrow out [R1]
        ar.ac = nib5[4]; // borrow from high nibble [R2]
        ar.ov = (ar.a[7] != ar.b[7]) && (sum9[7] != ar.a[7]); // [R5]
      end
      psmm_pkg::ARITH_MUL: begin
        prod = {8'h00, ar.a} * {8'h00, ar.b};
        ar.ov = (prod[15:8] != 8'h00); // [R6] [R8]
      end
      psmm_pkg::ARITH_DIV: begin
        ar.ov = (ar.b == 8'h00); // [R7] [R8]
      end
      psmm_pkg::ARITH_NONE: begin
        ci = 1'b0;
      end
      default: begin
        ci = 1'b0;
      end
    endcase
  end

endmodule : psmm_flag_calc

// File: test/cpu_status_word_and_memory_map_tb.sv
// cpu_status_word_and_memory_map_tb: self-checking bench for psmm_core_map.
// assumes the bench answers the sfr, rom and control window reads itself, same cycle.
`timescale 1ns/100ps
module cpu_status_word_and_memory_map_tb;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] acc_i = 8'h00;
  psmm_pkg::psmm_arith_t arith_op_i = psmm_pkg::ARITH_NONE;
  logic [7:0] arith_a_i = 8'h00;
  logic [7:0] arith_b_i = 8'h00;
  logic [7:0] psw_o;
  logic iram_req_i = 1'b0;
  logic iram_we_i = 1'b0;
  psmm_pkg::psmm_imode_t iram_mode_i = psmm_pkg::IMODE_DIRECT;
  logic [7:0] iram_addr_i = 8'h00;
  logic [2:0] reg_idx_i = 3'h0;
  logic [7:0] iram_wdata_i = 8'h00;
  logic [7:0] iram_rdata_o;
  logic iram_ack_o;
  logic sfr_req_o;
  logic sfr_we_o;
  logic [7:0] sfr_addr_o;
  logic [7:0] sfr_wdata_o;
  logic [7:0] sfr_rdata_i;
  logic code_req_i = 1'b0;
  psmm_pkg::psmm_cread_t code_kind_i = psmm_pkg::CREAD_FETCH;
  logic [15:0] code_addr_i = 16'h0000;
  logic [7:0] code_rdata_o;
  logic code_ack_o;
  logic [15:0] rom_addr_o;
  logic [7:0] rom_rdata_i;
  logic xdat_req_i = 1'b0;
  logic xdat_we_i = 1'b0;
  logic [15:0] xdat_addr_i = 16'h0000;
  logic [7:0] xdat_wdata_i = 8'h00;
  logic [7:0] xdat_rdata_o;
  logic xdat_ack_o;
  logic ext_mapped_ctrl_regs_req_o;
  logic ext_mapped_ctrl_regs_we_o;
  logic [7:0] ext_mapped_ctrl_regs_addr_o;
  logic [7:0] ext_mapped_ctrl_regs_wdata_o;
  logic [7:0] ext_mapped_ctrl_regs_rdata_i;
  logic sfr_seen;
  logic ext_mapped_ctrl_regs_seen;
  logic [7:0] rd;
  int bad_count = 0;
  int checks_done = 0;
  // arithmetic table: op, operands, expected {carry, aux, overflow}
  psmm_pkg::psmm_arith_t op_tab [9] = '{psmm_pkg::ARITH_ADD, psmm_pkg::ARITH_ADDC, psmm_pkg::ARITH_SUBB,
    psmm_pkg::ARITH_SUBB, psmm_pkg::ARITH_MUL, psmm_pkg::ARITH_MUL, psmm_pkg::ARITH_DIV,
    psmm_pkg::ARITH_DIV, psmm_pkg::ARITH_ADD};
  logic [7:0] a_tab [9] = '{8'h80, 8'h0F, 8'h00, 8'h80, 8'h10, 8'h02, 8'h05, 8'h06, 8'h7F};
  logic [7:0] b_tab [9] = '{8'h80, 8'h00, 8'h01, 8'h00, 8'h10, 8'h03, 8'h00, 8'h03, 8'h01};
  logic [2:0] f_tab [9] = '{3'h5, 3'h2, 3'h6, 3'h3, 3'h1, 3'h0, 3'h1, 3'h0, 3'h3};

  // clock, 100 ns period
  always #50 core_clk_i = ~core_clk_i;

  // far-side answers: distinct patterns per address so misrouting shows
  assign sfr_rdata_i = sfr_addr_o ^ 8'h5A;
  assign rom_rdata_i = rom_addr_o[7:0] ^ 8'hC3;
  assign ext_mapped_ctrl_regs_rdata_i = ext_mapped_ctrl_regs_addr_o + 8'h11;

  psmm_core_map u_psmm_core_map (.core_clk_i(core_clk_i), .rst_i(rst_i), .acc_i(acc_i),
    .arith_op_i(arith_op_i), .arith_a_i(arith_a_i), .arith_b_i(arith_b_i), .psw_o(psw_o),
    .iram_req_i(iram_req_i), .iram_we_i(iram_we_i), .iram_mode_i(iram_mode_i), .iram_addr_i(iram_addr_i),
    .reg_idx_i(reg_idx_i), .iram_wdata_i(iram_wdata_i), .iram_rdata_o(iram_rdata_o), .iram_ack_o(iram_ack_o),
    .sfr_req_o(sfr_req_o), .sfr_we_o(sfr_we_o), .sfr_addr_o(sfr_addr_o), .sfr_wdata_o(sfr_wdata_o),
    .sfr_rdata_i(sfr_rdata_i), .code_req_i(code_req_i), .code_kind_i(code_kind_i), .code_addr_i(code_addr_i),
    .code_rdata_o(code_rdata_o), .code_ack_o(code_ack_o), .rom_addr_o(rom_addr_o), .rom_rdata_i(rom_rdata_i),
    .xdat_req_i(xdat_req_i), .xdat_we_i(xdat_we_i), .xdat_addr_i(xdat_addr_i), .xdat_wdata_i(xdat_wdata_i),
    .xdat_rdata_o(xdat_rdata_o), .xdat_ack_o(xdat_ack_o), .ext_mapped_ctrl_regs_req_o(ext_mapped_ctrl_regs_req_o), .ext_mapped_ctrl_regs_we_o(ext_mapped_ctrl_regs_we_o),
    .ext_mapped_ctrl_regs_addr_o(ext_mapped_ctrl_regs_addr_o), .ext_mapped_ctrl_regs_wdata_o(ext_mapped_ctrl_regs_wdata_o), .ext_mapped_ctrl_regs_rdata_i(ext_mapped_ctrl_regs_rdata_i));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one internal memory access; ack and data looked at in the answer cycle
  task automatic mem(input logic we, input psmm_pkg::psmm_imode_t md, input logic [7:0] ad,
                     input logic [7:0] wd, output logic [7:0] rdat);
    @(negedge core_clk_i);
    iram_req_i = 1'b1;
    iram_we_i = we;
    iram_mode_i = md;
    iram_addr_i = ad;
    reg_idx_i = ad[2:0];
    iram_wdata_i = wd;
    #1 sfr_seen = sfr_req_o && (sfr_we_o == we) && (sfr_wdata_o == wd);
    @(negedge core_clk_i);
    iram_req_i = 1'b0;
    chk("iram ack", 8'h01, {7'h00, iram_ack_o});
    rdat = iram_rdata_o;
  endtask : mem

  task automatic cd(input psmm_pkg::psmm_cread_t k, input logic [15:0] ad, output logic [7:0] rdat);
    @(negedge core_clk_i);
    code_req_i = 1'b1;
    code_kind_i = k;
    code_addr_i = ad;
    @(negedge core_clk_i);
    code_req_i = 1'b0;
    chk("code ack", 8'h01, {7'h00, code_ack_o});
    rdat = code_rdata_o;
  endtask : cd

  task automatic xd(input logic we, input logic [15:0] ad, input logic [7:0] wd, output logic [7:0] rdat);
    @(negedge core_clk_i);
    xdat_req_i = 1'b1;
    xdat_we_i = we;
    xdat_addr_i = ad;
    xdat_wdata_i = wd;
    #1 ext_mapped_ctrl_regs_seen = ext_mapped_ctrl_regs_req_o && (ext_mapped_ctrl_regs_we_o == we) && (ext_mapped_ctrl_regs_wdata_o == wd);
    @(negedge core_clk_i);
    xdat_req_i = 1'b0;
    chk("xdata ack", 8'h01, {7'h00, xdat_ack_o});
    rdat = xdat_rdata_o;
  endtask : xd

  task automatic t_reset;
    logic [7:0] v [5] = '{8'h01, 8'h03, 8'h80, 8'hFF, 8'h7E};
    chk("status word after reset", 8'h00, psw_o);
    foreach (v[i]) begin
      @(negedge core_clk_i);
      acc_i = v[i];
      #1 chk("parity bit", {7'h00, ^v[i]}, {7'h00, psw_o[0]});
    end
    // odd accumulator must show up in a status word read too
    @(negedge core_clk_i);
    acc_i = 8'h07;
    mem(1'b0, psmm_pkg::IMODE_DIRECT, 8'hD0, 8'h00, rd);
    chk("parity in status read", 8'h01, rd);
    acc_i = 8'h00;
    $display("test reset/parity done");
  endtask : t_reset

  // user flags set first, so any hardware touch on them shows
  task automatic t_arith;
    mem(1'b1, psmm_pkg::IMODE_DIRECT, 8'hD0, 8'h22, rd);
    foreach (op_tab[i]) begin
      @(negedge core_clk_i);
      arith_op_i = op_tab[i];
      arith_a_i = a_tab[i];
      arith_b_i = b_tab[i];
      @(negedge core_clk_i);
      arith_op_i = psmm_pkg::ARITH_NONE;
      chk("flags after op", {f_tab[i][2:1], 3'b100, f_tab[i][0], 2'b10}, psw_o);
    end
    $display("test arithmetic flags done");
  endtask : t_arith

  task automatic t_bank;
    for (int n = 0; n < 4; n++) begin
      mem(1'b1, psmm_pkg::IMODE_DIRECT, 8'hD0, 8'(n << 3) | 8'h01, rd);
      chk("status write keeps parity", 8'(n << 3), psw_o);
      mem(1'b0, psmm_pkg::IMODE_DIRECT, 8'hD0, 8'h00, rd);
      chk("status direct read", 8'(n << 3), rd);
      mem(1'b1, psmm_pkg::IMODE_REG, 8'h05, 8'hA0 + 8'(n), rd);
      mem(1'b0, psmm_pkg::IMODE_INDIRECT, 8'(8 * n + 5), 8'h00, rd);
      chk("bank register byte", 8'hA0 + 8'(n), rd);
    end
    // status word bit access: user flag 0 sits at bit address 0xD5
    mem(1'b1, psmm_pkg::IMODE_BIT, 8'hD5, 8'h01, rd);
    chk("status bit write", 8'h38, psw_o);
    mem(1'b0, psmm_pkg::IMODE_BIT, 8'hD5, 8'h00, rd);
    chk("status bit read", 8'h01, rd);
    mem(1'b1, psmm_pkg::IMODE_DIRECT, 8'hD0, 8'h00, rd);
    $display("test bank select done");
  endtask : t_bank

  task automatic t_iram;
    mem(1'b1, psmm_pkg::IMODE_DIRECT, 8'h40, 8'hA5, rd);
    mem(1'b0, psmm_pkg::IMODE_INDIRECT, 8'h40, 8'h00, rd);
    chk("low ram direct to indirect", 8'hA5, rd);
    mem(1'b1, psmm_pkg::IMODE_INDIRECT, 8'h90, 8'h3C, rd);
    chk("indirect upper not to sfr", 8'h00, {7'h00, sfr_seen});
    mem(1'b1, psmm_pkg::IMODE_DIRECT, 8'h90, 8'h66, rd);
    chk("direct upper to sfr", 8'h01, {7'h00, sfr_seen});
    mem(1'b0, psmm_pkg::IMODE_DIRECT, 8'h90, 8'h00, rd);
    chk("direct upper read", 8'hCA, rd);
    chk("direct upper read to sfr", 8'h01, {7'h00, sfr_seen});
    mem(1'b0, psmm_pkg::IMODE_INDIRECT, 8'h90, 8'h00, rd);
    chk("upper ram separate", 8'h3C, rd);
    mem(1'b1, psmm_pkg::IMODE_DIRECT, 8'h22, 8'h00, rd);
    mem(1'b1, psmm_pkg::IMODE_BIT, 8'h13, 8'h01, rd);
    mem(1'b0, psmm_pkg::IMODE_DIRECT, 8'h22, 8'h00, rd);
    chk("bit write into byte", 8'h08, rd);
    mem(1'b0, psmm_pkg::IMODE_BIT, 8'h13, 8'h00, rd);
    chk("bit read", 8'h01, rd);
    $display("test internal memory done");
  endtask : t_iram

  task automatic t_xmap;
    xd(1'b1, 16'h0100, 8'h77, rd);
    cd(psmm_pkg::CREAD_FETCH, 16'h0100, rd);
    chk("fetch of data written", 8'h77, rd);
    cd(psmm_pkg::CREAD_CODE_SPACE_READ_INSTR, 16'h0100, rd);
    chk("code read of data written", 8'h77, rd);
    xd(1'b0, 16'h0100, 8'h00, rd);
    chk("data read of data written", 8'h77, rd);
    // write then fetch on the very next edge: one RAM behind both ports
    @(negedge core_clk_i);
    xdat_req_i = 1'b1;
    xdat_we_i = 1'b1;
    xdat_addr_i = 16'h0101;
    xdat_wdata_i = 8'h5E;
    @(negedge core_clk_i);
    xdat_req_i = 1'b0;
    code_req_i = 1'b1;
    code_kind_i = psmm_pkg::CREAD_FETCH;
    code_addr_i = 16'h0101;
    @(negedge core_clk_i);
    code_req_i = 1'b0;
    chk("fetch right after write", 8'h5E, code_rdata_o);
    cd(psmm_pkg::CREAD_FETCH, 16'h8010, rd);
    chk("rom fetch", 8'hD3, rd);
    cd(psmm_pkg::CREAD_CODE_SPACE_READ_INSTR, 16'h8010, rd);
    chk("rom code read hidden", psmm_pkg::UNDEF_BYTE, rd);
    xd(1'b0, 16'h8010, 8'h00, rd);
    chk("rom data read hidden", psmm_pkg::UNDEF_BYTE, rd);
    xd(1'b1, 16'h4005, 8'h12, rd);
    chk("window write forwarded", 8'h01, {7'h00, ext_mapped_ctrl_regs_seen});
    xd(1'b0, 16'h4005, 8'h00, rd);
    chk("window read", 8'h16, rd);
    chk("window read forwarded", 8'h01, {7'h00, ext_mapped_ctrl_regs_seen});
    xd(1'b0, 16'hC000, 8'h00, rd);
    chk("unmapped read", 8'h00, rd);
    $display("test unified map done");
  endtask : t_xmap

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // main sequence: 4 cycles of reset, then the tests
  initial begin
    repeat (4) @(negedge core_clk_i);
    rst_i = 1'b0;
    t_reset();
    t_arith();
    t_bank();
    t_iram();
    t_xmap();
    wrap_up();
  end

  // watchdog: tests need some 115 cycles, allow 5000
  initial begin
    #500000;
    bad_count++;
    wrap_up();
  end
endmodule : cpu_status_word_and_memory_map_tb
